//--- hw/pfc_host.sv
/*
  flash host controller: turns program, sector erase and chip erase requests into unlock
  sequences on the flash pins and polls the status bits for completion; reads take one read cycle.
  assumes a byte-wide flash with active-low strobes; dq_in arrives asynchronously.
*/
`default_nettype none
module pfc_host #(
  parameter int ERASE_TMO = pfc_pkg::ERASE_TMO_CYC,
  parameter logic [pfc_pkg::ADDR_W-1:0] UNLOCK_ADDR1 = pfc_pkg::UNL_ADDR1,
  parameter logic [pfc_pkg::ADDR_W-1:0] UNLOCK_ADDR2 = pfc_pkg::UNL_ADDR2,
  parameter logic [7:0] UNLOCK_DATA1 = pfc_pkg::UNL_DATA1,
  parameter logic [7:0] UNLOCK_DATA2 = pfc_pkg::UNL_DATA2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire pfc_pkg::pfc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output pfc_pkg::pfc_rsp_t rsp,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [pfc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe
);
  typedef enum logic [2:0] {
    PFC_IDLE, PFC_WRITE, PFC_WAIT_W, PFC_POLL, PFC_WAIT_R, PFC_RECHECK, PFC_DONE
  } pfc_st_t;
  pfc_st_t st_reg;
  pfc_pkg::pfc_req_t cur_reg;
  logic [2:0] step_reg;
  logic [7:0] prev_reg;
  logic first_reg;
  logic [1:0] rechk_reg;
  logic fail_reg;
  logic [31:0] tmo_reg;
  logic [7:0] dq_s1_reg;
  logic [7:0] dq_s2_reg;
  logic bc_start;
  logic bc_done;
  logic [7:0] bc_rdata;
  pfc_pkg::pfc_cyc_t cyc;

  // number of write cycles in each command sequence
  function automatic logic [2:0] seq_len(input pfc_pkg::pfc_op_t op);
    case (op)
      pfc_pkg::PFC_OP_PROG: seq_len = 3'h4; // R8
      pfc_pkg::PFC_OP_READ: seq_len = 3'h0;
      default: seq_len = 3'h6; // R12 R15
    endcase
  endfunction

  // address and data of write step n of the sequence for this request
  function automatic pfc_pkg::pfc_cyc_t seq_cyc(input pfc_pkg::pfc_req_t r,
                                                 input logic [2:0] n);
    logic [pfc_pkg::ADDR_W-1:0] sect;
    sect = {r.addr[pfc_pkg::ADDR_W-1:pfc_pkg::SECTOR_LSB], {pfc_pkg::SECTOR_LSB{1'b0}}};
    seq_cyc.wr = 1'b1;
    case (n)
      3'h0, 3'h3: begin
        seq_cyc.addr = UNLOCK_ADDR1; // R22
        seq_cyc.data = UNLOCK_DATA1;
      end
      3'h1, 3'h4: begin
        seq_cyc.addr = UNLOCK_ADDR2; // R22
        seq_cyc.data = UNLOCK_DATA2;
      end
      default: begin
        seq_cyc.addr = UNLOCK_ADDR1;
        seq_cyc.data = (r.op == pfc_pkg::PFC_OP_PROG) ? pfc_pkg::CMD_PROG
                                                       : pfc_pkg::CMD_ERASE_SETUP;
      end
    endcase
    if (r.op == pfc_pkg::PFC_OP_PROG && n == 3'h3) begin
      seq_cyc.addr = r.addr; // R8
      seq_cyc.data = r.data;
    end
    if (n == 3'h5) begin
      seq_cyc.addr = (r.op == pfc_pkg::PFC_OP_SECTOR) ? sect : pfc_pkg::CHIP_ERASE_ADDR;
      seq_cyc.data = (r.op == pfc_pkg::PFC_OP_SECTOR) ? pfc_pkg::CMD_SECTOR
                                                       : pfc_pkg::CMD_CHIP; // R12 R15
    end
  endfunction

  // operation finished: no toggle between two reads and polarity bit settled
  function automatic logic op_done(input pfc_pkg::pfc_req_t r, input logic [7:0] a,
                                   input logic [7:0] b);
    logic want;
    want = (r.op == pfc_pkg::PFC_OP_PROG) ? r.data[pfc_pkg::POL_BIT] : 1'b1; // R19
    op_done = (a[pfc_pkg::ALT_BIT] == b[pfc_pkg::ALT_BIT]) &&
              (b[pfc_pkg::POL_BIT] == want); // R20
  endfunction

  // two-flop synchroniser on the flash data pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // bus cycle request for the current state
  always_comb begin
    bc_start = (st_reg == PFC_WRITE) || (st_reg == PFC_POLL) || (st_reg == PFC_RECHECK);
    if (st_reg == PFC_WRITE) begin
      cyc = seq_cyc(cur_reg, step_reg);
    end else begin
      cyc.wr = 1'b0;
      cyc.addr = cur_reg.addr;
      cyc.data = 8'h00;
    end
  end

  pfc_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(bc_start),
    .cyc(cyc),
    .dq_sync(dq_s2_reg),
    .done(bc_done),
    .rdata(bc_rdata),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .addr(addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe)
  );

  // request sequencing and completion polling; no new command until completion or timeout
  always_ff @(posedge clk) begin
    rsp_valid <= 1'b0;
    if (!rst_n) begin
      st_reg <= PFC_IDLE;
      cur_reg <= '0;
      step_reg <= 3'h0;
      prev_reg <= 8'h00;
      first_reg <= 1'b0;
      rechk_reg <= 2'h0;
      fail_reg <= 1'b0;
      tmo_reg <= 32'h0;
      req_ready <= 1'b0;
      rsp <= '0;
    end else begin
      case (st_reg)
        PFC_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            cur_reg <= req;
            step_reg <= 3'h0;
            first_reg <= 1'b1;
            fail_reg <= 1'b0;
            rechk_reg <= 2'h0;
            // R7: the caller erases the sector before programming it
            tmo_reg <= (req.op == pfc_pkg::PFC_OP_PROG) ? 32'(pfc_pkg::PROG_TMO_CYC)
                                                       : 32'(ERASE_TMO);
            st_reg <= (req.op == pfc_pkg::PFC_OP_READ) ? PFC_POLL : PFC_WRITE;
          end
        end
        PFC_WRITE: st_reg <= PFC_WAIT_W;
        PFC_WAIT_W: if (bc_done) begin
          if (step_reg == seq_len(cur_reg.op) - 3'h1) begin
            st_reg <= PFC_POLL; // R17
          end else begin
            step_reg <= step_reg + 3'h1;
            st_reg <= PFC_WRITE;
          end
        end
        PFC_POLL: st_reg <= PFC_WAIT_R;
        PFC_WAIT_R: begin
          if (tmo_reg != 32'h0) begin
            tmo_reg <= tmo_reg - 32'h1;
          end
          if (bc_done) begin
            prev_reg <= bc_rdata;
            first_reg <= 1'b0;
            if (cur_reg.op == pfc_pkg::PFC_OP_READ) begin
              st_reg <= PFC_DONE;
            end else if (!first_reg && op_done(cur_reg, prev_reg, bc_rdata)) begin
              if (rechk_reg == 2'(pfc_pkg::RECHECK_READS)) begin
                st_reg <= PFC_DONE; // R18
              end else begin
                rechk_reg <= rechk_reg + 2'h1;
                st_reg <= PFC_RECHECK;
              end
            end else if (tmo_reg == 32'h0) begin
              fail_reg <= 1'b1; // R9
              st_reg <= PFC_DONE;
            end else begin
              rechk_reg <= 2'h0; // R18
              st_reg <= PFC_POLL; // R10 R11 R14 R16
            end
          end
        end
        PFC_RECHECK: st_reg <= PFC_WAIT_R;
        PFC_DONE: begin
          rsp_valid <= 1'b1;
          rsp.data <= prev_reg;
          rsp.fail <= fail_reg;
          st_reg <= PFC_IDLE;
        end
        default: st_reg <= PFC_IDLE;
      endcase
    end
  end

  // no write strobe while polling a busy flash
  property p_no_write_when_busy;
    @(posedge clk) disable iff (!rst_n)
      (st_reg == PFC_WAIT_R) |-> we_n;
  endproperty
  a_no_write_when_busy: assert property (p_no_write_when_busy) // R11
    else $error("write while busy");

  // a response follows the done state one cycle later
  sequence s_done;
    st_reg == PFC_DONE;
  endsequence
  property p_rsp_after_done;
    @(posedge clk) disable iff (!rst_n) s_done |=> rsp_valid ##1 !rsp_valid;
  endproperty
  a_rsp_after_done: assert property (p_rsp_after_done) else $error("response missing"); // R18

  // busy: not ready to accept a request outside idle
  property p_ready_idle;
    @(posedge clk) disable iff (!rst_n) req_ready |-> st_reg == PFC_IDLE;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready while busy"); // R11

  // select is high whenever the sequencer is idle and has been for a cycle
  property p_idle_deselect;
    @(posedge clk) disable iff (!rst_n)
      (st_reg == PFC_IDLE && $past(st_reg) == PFC_IDLE) |-> ce_n && oe_n && !dq_oe;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect) else $error("bus active in idle"); // R6

  // a program never reports done without the polarity bit matching written data
  property p_prog_polarity;
    @(posedge clk) disable iff (!rst_n)
      (rsp_valid && !rsp.fail && cur_reg.op == pfc_pkg::PFC_OP_PROG) |->
        rsp.data[pfc_pkg::POL_BIT] == cur_reg.data[pfc_pkg::POL_BIT];
  endproperty
  a_prog_polarity: assert property (p_prog_polarity) else $error("program polarity"); // R19
endmodule
`default_nettype wire

//--- common/pfc_pkg.sv
/*
  package for the parallel flash host controller: bus strobe timing, command codes,
  unlock sequence defaults, status bit positions and the request/answer structs.
  assumes a 50 MHz clock and a byte-wide flash with active-low strobes.
*/
// Contract
// [R1] host writes a command by pulling write strobe low while chip select is low
// [R2] flash latches the address at the later falling strobe edge
// [R3] flash latches data at the earlier rising strobe edge; host holds data across it
// [R4] flash drives data only with select and output gate low; host asserts both to read
// [R5] flash data bus floats when select or output gate is high
// [R6] select high deselects the flash; it ignores the bus
// [R7] host erases the sector before programming any byte in it; pfc_host does not erase, it leaves this to the caller
// [R8] byte program is three unlock writes then one address/data write
// [R9] internal byte programming ends within 20 us
// [R10] while programming, reads return only status bits
// [R11] commands written during byte programming are ignored
// [R12] sector erase is six writes, last carries 30H and sector address
// [R13] sector erase latches block address and command on sixth write strobe
// [R14] commands written during sector erase are ignored
// [R15] chip erase is six writes ending with 10H at 5555H
// [R16] during chip erase only status reads are valid
// [R17] two completion status bits are valid from the launching rising strobe
// [R18] on inconsistent status, reread twice; both valid confirms completion
// [R19] polarity bit is complement of data while programming, zero while erasing
// [R20] alternating bit toggles on each read while busy, stops when done
// [R21] an invalid unlock cycle sends the flash back to read mode
// [R22] unlock addresses and data are parameters of the sequencer
`default_nettype none
package pfc_pkg;
  localparam int ADDR_W = 19;
  localparam int CLK_NS = 20;
  // strobe phases in ns, converted to cycles (rounded up)
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 60;
  localparam int HOLD_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  // timeout budgets in us
  localparam int PROG_MAX_US = 20;
  localparam int ERASE_MAX_US = 100000;
  localparam int PROG_TMO_CYC = PROG_MAX_US * 1000 / CLK_NS;
  localparam int ERASE_TMO_CYC = ERASE_MAX_US * 1000 / CLK_NS;
  // unlock sequence defaults
  localparam logic [ADDR_W-1:0] UNL_ADDR1 = 19'h05555;
  localparam logic [ADDR_W-1:0] UNL_ADDR2 = 19'h02AAA;
  localparam logic [7:0] UNL_DATA1 = 8'hAA;
  localparam logic [7:0] UNL_DATA2 = 8'h55;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [ADDR_W-1:0] CHIP_ERASE_ADDR = 19'h05555;
  localparam int SECTOR_LSB = 12;
  localparam int POL_BIT = 7;
  localparam int ALT_BIT = 6;
  localparam int RECHECK_READS = 2;
  typedef enum logic [1:0] {PFC_OP_READ, PFC_OP_PROG, PFC_OP_SECTOR, PFC_OP_CHIP} pfc_op_t;
  typedef struct packed {
    pfc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } pfc_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic fail;
  } pfc_rsp_t;
  // one bus cycle for the strobe engine
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } pfc_cyc_t;
endpackage
`default_nettype wire

//--- hw/pfc_bus_cycle.sv
/*
  single flash bus cycle engine: one write or read with setup, strobe and hold phases.
  assumes the caller waits for done before starting the next cycle.
*/
`default_nettype none
module pfc_bus_cycle (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire pfc_pkg::pfc_cyc_t cyc,
  input wire logic [7:0] dq_sync,
  output logic done,
  output logic [7:0] rdata,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [pfc_pkg::ADDR_W-1:0] addr,
  output logic [7:0] dq_out,
  output logic dq_oe
);
  typedef enum logic [1:0] {PFC_BC_IDLE, PFC_BC_SETUP, PFC_BC_PULSE, PFC_BC_HOLD} pfc_bc_t;
  pfc_bc_t st_reg;
  logic [3:0] cnt_reg;
  logic wr_reg;
  // sync input latency plus pulse width before sampling reads
  localparam logic [3:0] SETUP_N = 4'(pfc_pkg::SETUP_CYC);
  localparam logic [3:0] PULSE_N = 4'(pfc_pkg::PULSE_CYC + 2);
  localparam logic [3:0] HOLD_N = 4'(pfc_pkg::HOLD_CYC);

  // phase sequencer; address set before strobe so flash sees it at the falling edge
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (!rst_n) begin
      st_reg <= PFC_BC_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      addr <= '0;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      rdata <= 8'h00;
    end else begin
      case (st_reg)
        PFC_BC_IDLE: if (start) begin
          addr <= cyc.addr;
          dq_out <= cyc.data;
          wr_reg <= cyc.wr;
          ce_n <= 1'b0;
          cnt_reg <= SETUP_N;
          st_reg <= PFC_BC_SETUP;
        end
        PFC_BC_SETUP: begin
          if (cnt_reg == 4'h1) begin
            we_n <= ~wr_reg; // R1
            oe_n <= wr_reg; // R4
            dq_oe <= wr_reg;
            cnt_reg <= wr_reg ? 4'(pfc_pkg::PULSE_CYC) : PULSE_N;
            st_reg <= PFC_BC_PULSE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        PFC_BC_PULSE: begin
          if (cnt_reg == 4'h1) begin
            if (!wr_reg) begin
              rdata <= dq_sync;
            end
            we_n <= 1'b1; // R3
            oe_n <= 1'b1; // R5
            cnt_reg <= HOLD_N;
            st_reg <= PFC_BC_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        PFC_BC_HOLD: begin
          if (cnt_reg == 4'h1) begin
            ce_n <= 1'b1; // R6
            dq_oe <= 1'b0;
            done <= 1'b1;
            st_reg <= PFC_BC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: st_reg <= PFC_BC_IDLE;
      endcase
    end
  end

  // never drive data toward the flash while its output gate is low
  property p_no_contention;
    @(posedge clk) disable iff (!rst_n) !(dq_oe && !oe_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention"); // R4

  // data stays driven one hold period after write strobe rises
  property p_data_hold;
    @(posedge clk) disable iff (!rst_n) $rose(we_n) |-> dq_oe [*2];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data not held"); // R3

  // write strobe only falls with select already low
  property p_we_under_ce;
    @(posedge clk) disable iff (!rst_n) $fell(we_n) |-> !ce_n && $past(!ce_n);
  endproperty
  a_we_under_ce: assert property (p_we_under_ce) else $error("write without select"); // R1
endmodule
`default_nettype wire

//--- test/pfc_flash_model.sv
/*
  behavioural byte-wide flash for the host controller bench: unlock decoding,
  byte program, sector and chip erase, busy status bits and a write checker.
  assumes one host on the strobes; busy times are in ns, defaulted in the model; the bench only changes erase_ns.
*/
`default_nettype none
module pfc_flash_model #(
  parameter logic [pfc_pkg::ADDR_W-1:0] UNLOCK_ADDR1 = pfc_pkg::UNL_ADDR1,
  parameter logic [pfc_pkg::ADDR_W-1:0] UNLOCK_ADDR2 = pfc_pkg::UNL_ADDR2,
  parameter logic [7:0] UNLOCK_DATA1 = pfc_pkg::UNL_DATA1,
  parameter logic [7:0] UNLOCK_DATA2 = pfc_pkg::UNL_DATA2
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [pfc_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] dq_wr,
  output logic [7:0] dq_rd,
  output logic dq_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic busy = 1'b0;
  logic erasing = 1'b0;
  logic tog = 1'b0;
  logic [7:0] pdata = 8'h00;
  logic [pfc_pkg::ADDR_W-1:0] a_lat = '0;
  logic [pfc_pkg::ADDR_W-1:0] last_addr = '0;
  int prog_ns = 4000;
  int erase_ns = 10000;
  int step = 0;
  int nstep;
  int base;
  int wr_count = 0;
  int viol = 0;
  int last_kind = 0;
  wire wsel;
  wire rsel;
  assign wsel = ce_n | we_n;
  assign rsel = ce_n | oe_n;
  // busy window of one internal operation
  task automatic launch(input int t, input logic er);
    busy = 1'b1;
    erasing = er;
    fork
      begin
        #(t);
        busy = 1'b0;
      end
    join_none
  endtask
  // address taken when the later of the two strobes falls
  always @(negedge wsel) a_lat = addr;
  // write strobe must sit inside chip select and never overlap a read
  always @(negedge we_n) if (ce_n !== 1'b0 || oe_n !== 1'b1) viol++;
  // data taken at the earlier rising strobe; the unlock walk advances
  always @(posedge wsel) begin
    wr_count++;
    if (!busy) begin
      nstep = 0;
      if ((step == 0 || step == 4) && a_lat === UNLOCK_ADDR1 && dq_wr === UNLOCK_DATA1)
        nstep = step + 1;
      if ((step == 1 || step == 5) && a_lat === UNLOCK_ADDR2 && dq_wr === UNLOCK_DATA2)
        nstep = step + 1;
      if (step == 2 && a_lat === UNLOCK_ADDR1 && dq_wr === pfc_pkg::CMD_PROG) nstep = 3;
      if (step == 2 && a_lat === UNLOCK_ADDR1 && dq_wr === pfc_pkg::CMD_ERASE_SETUP) nstep = 4;
      if (step == 3) begin
        if (mem.exists(int'(a_lat)) && mem[int'(a_lat)] !== 8'hFF) viol++;
        mem[int'(a_lat)] = dq_wr;
        pdata = dq_wr;
        last_kind = 1;
        launch(prog_ns, 1'b0);
      end
      if (step == 6 && dq_wr === pfc_pkg::CMD_SECTOR) begin
        base = (int'(a_lat) >> pfc_pkg::SECTOR_LSB) << pfc_pkg::SECTOR_LSB;
        for (int k = 0; k < (1 << pfc_pkg::SECTOR_LSB); k++)
          if (mem.exists(base + k)) mem.delete(base + k);
        last_kind = 2;
        launch(erase_ns, 1'b1);
      end
      if (step == 6 && a_lat === pfc_pkg::CHIP_ERASE_ADDR && dq_wr === pfc_pkg::CMD_CHIP) begin
        mem.delete();
        last_kind = 3;
        launch(erase_ns, 1'b1);
      end
      last_addr = a_lat;
      step = nstep;
    end
  end
  // outputs only while selected and gated, floating otherwise
  assign dq_drv = (rsel === 1'b0);
  always @(negedge rsel) if (busy) tog = ~tog;
  // status bits while busy, array data otherwise
  always @(rsel or busy or tog or addr) begin
    if (busy) dq_rd = {erasing ? 1'b0 : ~pdata[7], tog, 6'h2A};
    else dq_rd = mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hFF;
  end
endmodule
`default_nettype wire

//--- test/pfc_host_tb_top.sv
/*
  testbench for the flash host controller: requests read, program, sector and chip
  erase against the flash model and judges data, write counts and timeouts.
  assumes the package and both modules are compiled before this file.
*/
`default_nettype none
module pfc_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  pfc_pkg::pfc_req_t req = '0;
  pfc_pkg::pfc_rsp_t rsp;
  pfc_pkg::pfc_rsp_t got;
  logic req_ready, rsp_valid, ce_n, we_n, oe_n, dq_oe, fl_drv;
  logic [pfc_pkg::ADDR_W-1:0] addr;
  logic [7:0] dq_in, dq_out, fl_dq;
  logic [7:0] idle_q = 8'h00;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int w0;
  initial forever #10 clk = ~clk;
  // released bus holds the inverse of the last driven value
  always @(posedge clk) if (dq_oe || fl_drv) idle_q <= ~dq_in;
  assign dq_in = dq_oe ? dq_out : (fl_drv ? fl_dq : idle_q);
  pfc_host #(.ERASE_TMO(2000), .UNLOCK_ADDR1(19'h00555), .UNLOCK_ADDR2(19'h002AA))
    u_pfc_host (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  pfc_flash_model #(.UNLOCK_ADDR1(19'h00555), .UNLOCK_ADDR2(19'h002AA))
    u_pfc_flash_model (.ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_wr(dq_out), .dq_rd(fl_dq), .dq_drv(fl_drv));
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check_bit(input logic g, input logic e, input string m);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t ns: %s got %b", $time, m, g);
    end
  endtask
  task automatic check_val(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  // one request, held until taken, then wait for the answer
  task automatic do_req(input pfc_pkg::pfc_op_t op, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req.op = op;
    req.addr = a;
    req.data = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    check_bit(req_ready, 1'b0, "ready after take");
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    got = rsp;
    check_bit(rsp_valid, 1'b1, "no response");
  endtask
  task automatic rd_chk(input logic [18:0] a, input logic [7:0] e);
    do_req(pfc_pkg::PFC_OP_READ, a, 8'h00);
    check_val(got.data, e, "read data");
    check_bit(got.fail, 1'b0, "read fail");
  endtask
  task automatic t_read();
    u_pfc_flash_model.mem[32'h01234] = 8'h5C;
    u_pfc_flash_model.mem[32'h03456] = 8'h11;
    u_pfc_flash_model.mem[32'h04000] = 8'h22;
    w0 = u_pfc_flash_model.wr_count;
    rd_chk(19'h01234, 8'h5C);
    check_val(u_pfc_flash_model.wr_count - w0, 0, "writes on read");
  endtask
  task automatic t_sector();
    w0 = u_pfc_flash_model.wr_count;
    do_req(pfc_pkg::PFC_OP_SECTOR, 19'h03456, 8'h00);
    check_bit(got.fail, 1'b0, "erase fail");
    check_bit(u_pfc_flash_model.busy, 1'b0, "done while busy");
    check_val(u_pfc_flash_model.wr_count - w0, 6, "erase writes");
    check_val(u_pfc_flash_model.last_kind, 2, "erase kind");
    check_val(u_pfc_flash_model.last_addr, 19'h03000, "block address");
    rd_chk(19'h03456, 8'hFF);
    rd_chk(19'h04000, 8'h22);
  endtask
  task automatic t_prog();
    w0 = u_pfc_flash_model.wr_count;
    do_req(pfc_pkg::PFC_OP_PROG, 19'h03456, 8'h3C);
    check_bit(got.fail, 1'b0, "program fail");
    check_bit(u_pfc_flash_model.busy, 1'b0, "done while busy");
    check_val(u_pfc_flash_model.wr_count - w0, 4, "program writes");
    check_val(u_pfc_flash_model.last_kind, 1, "program kind");
    do_req(pfc_pkg::PFC_OP_PROG, 19'h03457, 8'hC3);
    check_bit(u_pfc_flash_model.busy, 1'b0, "done while busy");
    rd_chk(19'h03456, 8'h3C);
    rd_chk(19'h03457, 8'hC3);
  endtask
  task automatic t_chip();
    w0 = u_pfc_flash_model.wr_count;
    do_req(pfc_pkg::PFC_OP_CHIP, 19'h01234, 8'h00);
    check_bit(got.fail, 1'b0, "chip fail");
    check_val(u_pfc_flash_model.wr_count - w0, 6, "chip writes");
    check_val(u_pfc_flash_model.last_addr, 19'h05555, "chip address");
    check_val(u_pfc_flash_model.last_kind, 3, "chip kind");
    rd_chk(19'h04000, 8'hFF);
    rd_chk(19'h01234, 8'hFF);
  endtask
  // flash slower than the host budget: the answer must flag failure
  task automatic t_slow();
    u_pfc_flash_model.erase_ns = 60000;
    do_req(pfc_pkg::PFC_OP_SECTOR, 19'h05000, 8'h00);
    check_bit(got.fail, 1'b1, "timeout flag");
  endtask
  // host and flash must never drive the data bus together
  always @(posedge clk)
    if (rst_n && dq_oe === 1'b1 && fl_drv === 1'b1) check_bit(1'b0, 1'b1, "clash");
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_read();
    t_sector();
    t_prog();
    t_chip();
    check_val(u_pfc_flash_model.viol, 0, "host write faults");
    t_slow();
    stop_test();
  end
endmodule
`default_nettype wire
